// File: common/nvm_port_regs.svh
// Constants for the serial nonvolatile access port, both ends.
// Assumes a 200 MHz host clock and a 48 ns device oscillator.
// Functional notes
// - Host holds lines low, then startup wait
// - Code 1,0,0 selects programming
// - 128 bits from location zero, sampled falling
// - Host holds clock low 15 ms per bit
// - Code 1,0,1 selects readout
// - Device drives each bit after rising edge
// - Drive 8 to 16 cycles, release within 16
// - Host releases data before rising edge
// - Code 1,1,1 erases while clock low
// - Host holds clock low 30 ms erasing
// - Clock high phase at least 64 cycles
// - Clock low phase at least 64 cycles
// - Data setup 0, hold 16 cycles
// - First fall 5 cycles after reset release
// - Falls closer than watchdog limit
// - After last bit, data low, clock low
// - After erase: clock high, data low, low
// - First bit ignored, next two decoded
// - Data low 8 cycles after reset release
// - Data on port pin, clock on interrupt pin
`ifndef NVM_PORT_REGS_SVH
`define NVM_PORT_REGS_SVH

`define ARRAY_BITS        128
`define LAST_ADDR         8'h7f
`define OPC_LAST_IDX      8'h02
`define DATA_FIRST_IDX    8'h03
`define LAST_DATA_IDX     8'h82
`define ERASED_BIT        1'b0

`define MCLK_PERIOD_NS    5
`define OSC_PERIOD_NS     48
`define NS_PER_MS         1000000
`define STARTUP_OSC       4064
`define STARTUP_SHORT_OSC 16
`define CLK_PHASE_OSC     64
`define PHASE_MARGIN_OSC  8
`define DATA_HOLD_OSC     16
`define RST_DATA_LOW_OSC  8
`define RST_TO_FALL_OSC   5
`define PROG_TIME_MS      15
`define ERASE_TIME_MS     30
`define WDOG_MAX_OSC      (6 * (1 << 17))

`define DRV_MIN_OSC       8
`define DRV_MAX_OSC       16
`define HIZ_MAX_OSC       16
`define SYNC_LAT_OSC      2
`define DRV_WAIT_OSC      (`DRV_MIN_OSC - `SYNC_LAT_OSC)

`define OSC_TO_MCLK(n)    ((((n) * `OSC_PERIOD_NS) + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define MS_TO_MCLK(n)     (((n) * `NS_PER_MS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define HI_MCLK           `OSC_TO_MCLK(`CLK_PHASE_OSC + `PHASE_MARGIN_OSC)
`define HOLD_MCLK         `OSC_TO_MCLK(`DATA_HOLD_OSC + `PHASE_MARGIN_OSC)
`define SETTLE_MCLK       `OSC_TO_MCLK(`RST_DATA_LOW_OSC + `PHASE_MARGIN_OSC)
`define STARTUP_MCLK      `OSC_TO_MCLK(`STARTUP_OSC)
`define PROG_MCLK         `MS_TO_MCLK(`PROG_TIME_MS)
`define ERASE_MCLK        `MS_TO_MCLK(`ERASE_TIME_MS)

`define CNT_W             24
`define DRV_CNT_W         4

`endif

// File: common/nvm_port_pkg.sv
// Types shared by both ends of the serial nonvolatile port.
// Assumes the constants header sits beside it.
`include "nvm_port_regs.svh"
`default_nettype none

package nvm_port_pkg;

  // Operation code, second and third sampled bits
  typedef enum logic [1:0] {
    OP_PROGRAM    = 2'h0,
    OP_READ       = 2'h1,
    OP_UNASSIGNED = 2'h2,
    OP_ERASE      = 2'h3
  } nv_op_e;

  // Device decoder states
  typedef enum logic [5:0] {
    DS_IDLE   = 6'h01,
    DS_OPCODE = 6'h02,
    DS_PROG   = 6'h04,
    DS_READ   = 6'h08,
    DS_ERASE  = 6'h10,
    DS_DONE   = 6'h20
  } dev_state_e;

  // Host sequencer states
  typedef enum logic [7:0] {
    PS_IDLE    = 8'h01,
    PS_STARTUP = 8'h02,
    PS_SETTLE  = 8'h04,
    PS_HI      = 8'h08,
    PS_LO      = 8'h10,
    PS_RISE    = 8'h20,
    PS_DATALOW = 8'h40,
    PS_FALL    = 8'h80
  } prog_state_e;

  // Whole array image
  typedef logic [`ARRAY_BITS-1:0] nv_image_t;

endpackage

`default_nettype wire

// File: common/nvm_link_if.sv
// Link between the serial programmer and the device port.
// Assumes the bench resolves nothing else; data line pulls low.
`timescale 1ns/10ps
`default_nettype none

interface nvm_link_if;
  logic reset_pin_n;     // Device reset pin, host driven
  logic sel_clk;         // Select clock on interrupt pin
  logic prog_data_out;   // Host data drive value
  logic prog_data_oe_n;  // Host drive enable, low drives
  logic dev_data_out;    // Device data drive value
  logic dev_data_oe_n;   // Device drive enable, low drives
  logic data_line;       // Resolved serial data pin

  // Resolve the shared pin, weak pull-down when idle
  assign data_line = !prog_data_oe_n ? prog_data_out :
                     !dev_data_oe_n  ? dev_data_out  : 1'b0;

  modport device (
    input  reset_pin_n, sel_clk, data_line,
    output dev_data_out, dev_data_oe_n
  );

  modport programmer (
    input  data_line,
    output reset_pin_n, sel_clk, prog_data_out, prog_data_oe_n
  );
endinterface

`default_nettype wire

// File: hw/nvm_serial_device.sv
// Device end: decoder, array and read driver on the oscillator clock.
// Assumes link pins are asynchronous to the oscillator.
`timescale 1ns/10ps
`default_nettype none

module nvm_serial_device
  import nvm_port_pkg::*;
(
  input  wire logic        osc_clk_in,    // Device oscillator, link clock
  input  wire logic        rst_in,        // Power-on reset, active high
  nvm_link_if.device       link,          // Pins to the programmer
  output var  nv_image_t   nv_array_out,  // Stored array contents
  output logic             active_out     // Operation under way
);

  logic [2:0]  sync_a_r;    // First stage, read only by second
  logic [2:0]  sync_b_r;    // Second stage
  logic        sel_d_r;     // Delayed clock for edges
  logic        rstn_d_r;    // Delayed reset for release edge
  dev_state_e  state_r;
  dev_state_e  state_nxt;
  logic [7:0]  bit_cnt_r;
  logic [7:0]  bit_cnt_nxt;
  logic [1:0]  opc_r;       // Last two sampled code bits
  logic [1:0]  opc_nxt;
  nv_image_t   array_r;
  logic [`DRV_CNT_W-1:0] drv_cnt_r;
  logic [`DRV_CNT_W-1:0] drv_cnt_nxt;
  logic        dout_r;
  logic        dout_nxt;
  logic        doe_n_r;
  logic        doe_n_nxt;
  logic        active_r;

  // Synchronised pins and their edges
  wire sel_s    = sync_b_r[2];
  wire rstn_s   = sync_b_r[1];
  wire data_s   = sync_b_r[0];
  wire sel_fall = !sel_s && sel_d_r;
  wire sel_rise = sel_s && !sel_d_r;
  wire rst_rel  = rstn_s && !rstn_d_r;
  wire [1:0] code_w  = {opc_r[0], data_s};
  wire [6:0] addr_w  = bit_cnt_r[6:0];
  wire last_bit_w    = (bit_cnt_r == `LAST_ADDR);
  wire erasing_w     = (state_r == DS_ERASE) && !sel_s;

  // Two-flop synchronisers on all link inputs
  always_ff @(posedge osc_clk_in) begin
    sync_a_r <= {link.sel_clk, link.reset_pin_n, link.data_line};
    sync_b_r <= sync_a_r;
    sel_d_r  <= sel_s;
    rstn_d_r <= rstn_s;
  end

  // Operation decoder
  always_comb begin
    state_nxt   = state_r;
    bit_cnt_nxt = bit_cnt_r;
    opc_nxt     = opc_r;
    if (!rstn_s) begin
      state_nxt = DS_IDLE;                    // Pin reset reinitialises
    end else begin
      unique case (state_r)
        DS_IDLE: if (rst_rel) begin
          state_nxt   = DS_OPCODE;
          bit_cnt_nxt = 8'h00;
        end
        DS_OPCODE: if (sel_fall) begin
          opc_nxt     = code_w;               // First bit shifts out unused
          bit_cnt_nxt = bit_cnt_r + 8'h01;
          if (bit_cnt_r == `OPC_LAST_IDX) begin
            bit_cnt_nxt = 8'h00;              // Data starts at location zero
            unique case (nv_op_e'(code_w))
              OP_PROGRAM:    state_nxt = DS_PROG;
              OP_READ:       state_nxt = DS_READ;
              OP_ERASE:      state_nxt = DS_ERASE;
              OP_UNASSIGNED: state_nxt = DS_DONE;
            endcase
          end
        end
        DS_PROG, DS_READ: if (sel_fall) begin
          bit_cnt_nxt = bit_cnt_r + 8'h01;
          if (last_bit_w) state_nxt = DS_DONE;     // 128 bits then stop
        end
        DS_ERASE: if (sel_rise) state_nxt = DS_DONE;
        DS_DONE: state_nxt = DS_DONE;              // Edges ignored
      endcase
    end
  end

  // Read driver: release on rise, drive after a short wait
  always_comb begin
    drv_cnt_nxt = '0;
    dout_nxt    = dout_r;
    doe_n_nxt   = 1'b1;
    if (state_r == DS_READ) begin
      doe_n_nxt = doe_n_r;
      if (sel_rise) begin
        doe_n_nxt   = 1'b1;                             // Hi-Z well inside 16
        drv_cnt_nxt = `DRV_CNT_W'(`DRV_WAIT_OSC);
      end else if (drv_cnt_r != '0) begin
        drv_cnt_nxt = drv_cnt_r - `DRV_CNT_W'(1);
        if (drv_cnt_r == `DRV_CNT_W'(1)) begin
          doe_n_nxt = 1'b0;                             // Drive 8 to 9 after rise
          dout_nxt  = array_r[addr_w];
        end
      end else if (sel_fall && last_bit_w) begin
        doe_n_nxt = 1'b1;                               // Free pin after last bit
      end
    end
  end

  // Control state
  always_ff @(posedge osc_clk_in) begin
    if (rst_in) begin
      state_r   <= DS_IDLE;
      bit_cnt_r <= 8'h00;
      opc_r     <= 2'h0;
      drv_cnt_r <= '0;
      dout_r    <= 1'b0;
      doe_n_r   <= 1'b1;
      active_r  <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      opc_r     <= opc_nxt;
      drv_cnt_r <= drv_cnt_nxt;
      dout_r    <= dout_nxt;
      doe_n_r   <= doe_n_nxt;
      active_r  <= !(state_nxt inside {DS_IDLE, DS_DONE});
    end
  end

  // Array: program sets bits on falls, erase clears while low
  always_ff @(posedge osc_clk_in) begin
    if (rst_in) begin
      array_r <= {`ARRAY_BITS{`ERASED_BIT}};
    end else if (erasing_w && rstn_s) begin
      array_r <= {`ARRAY_BITS{`ERASED_BIT}};
    end else if (state_r == DS_PROG && sel_fall && rstn_s) begin
      array_r[addr_w] <= array_r[addr_w] | data_s;     // Sampled at fall
    end
  end

  assign link.dev_data_out  = dout_r;
  assign link.dev_data_oe_n = doe_n_r;
  assign nv_array_out       = array_r;
  assign active_out         = active_r;

endmodule // nvm_serial_device

`default_nettype wire

// File: hw/nvm_serial_programmer.sv
// Host end: sequences reset, select clock and data for one operation.
// Assumes the device oscillator period given in the constants header.
`timescale 1ns/10ps
`default_nettype none

module nvm_serial_programmer
  import nvm_port_pkg::*;
#(
  parameter logic [`CNT_W-1:0] STARTUP_CYC = `CNT_W'(`STARTUP_MCLK), // Reset hold
  parameter logic [`CNT_W-1:0] PROG_CYC    = `CNT_W'(`PROG_MCLK),    // Per-bit low
  parameter logic [`CNT_W-1:0] ERASE_CYC   = `CNT_W'(`ERASE_MCLK)    // Erase low
)
(
  input  wire logic        mclk_in,       // Host clock, 200 MHz
  input  wire logic        rst_in,        // Synchronous reset, active high
  input  wire logic        start_in,      // Start pulse, taken when idle
  input  wire logic [1:0]  op_in,         // Operation code
  input  wire nv_image_t   wr_image_in,   // Image to program
  output var  nv_image_t   rd_image_out,  // Image read back
  output logic             busy_out,      // Sequence in progress
  output logic             done_out,      // One-cycle end pulse
  nvm_link_if.programmer   link           // Pins to the device
);

  prog_state_e       state_r;
  prog_state_e       state_nxt;
  logic [`CNT_W-1:0] cnt_r;        // Phase timer
  logic [`CNT_W-1:0] cnt_nxt;
  logic [7:0]        bidx_r;       // Clock pulse index, code then data
  logic [7:0]        bidx_nxt;
  nv_op_e            op_r;         // Latched operation
  nv_image_t         wr_r;         // Latched write image
  nv_image_t         rd_r;         // Collected read image
  logic [1:0]        data_sync_r;  // Data pin synchroniser
  logic              rstn_r;       // Registered pins
  logic              sel_r;
  logic              dout_r;
  logic              doe_n_r;
  logic              busy_r;
  logic              done_r;

  // Pulse decode
  wire       in_data_w   = (bidx_r >= `DATA_FIRST_IDX);
  wire [6:0] dpos_w      = 7'(bidx_r - `DATA_FIRST_IDX);
  wire       is_read_w   = (op_r == OP_READ);
  wire       is_prog_w   = (op_r == OP_PROGRAM);
  wire       is_erase_w  = (op_r == OP_ERASE);
  wire       read_data_w = is_read_w && in_data_w;
  wire [7:0] last_idx_w  = is_erase_w ? `OPC_LAST_IDX : `LAST_DATA_IDX;
  wire       last_w      = (bidx_r == last_idx_w);
  wire       data_s      = data_sync_r[1];

  // Bit on the data line: leading one, then code, then image
  wire       code_bit_w  = (bidx_r == 8'h00) ? 1'b1 :
                           (bidx_r == 8'h01) ? op_r[1] : op_r[0];
  wire       cur_bit_w   = in_data_w ? wr_r[dpos_w] : code_bit_w;

  // Low phase length by pulse kind
  wire [`CNT_W-1:0] lo_len_w =
      (is_prog_w && in_data_w)                 ? PROG_CYC :
      (is_erase_w && bidx_r == `OPC_LAST_IDX)  ? ERASE_CYC :
                                                 `CNT_W'(`HI_MCLK);

  // Phase length of the current state
  wire [`CNT_W-1:0] len_w =
      (state_r == PS_STARTUP) ? STARTUP_CYC :
      (state_r == PS_SETTLE)  ? `CNT_W'(`SETTLE_MCLK) :
      (state_r == PS_LO)      ? lo_len_w :
                                `CNT_W'(`HI_MCLK);
  wire phase_end_w = (cnt_r == len_w - `CNT_W'(1));

  // Host lets go of data after the hold time when a read is coming
  // Data lows stay free: the device holds its bit past the fall
  wire release_lo_w = is_read_w && ((bidx_r > `OPC_LAST_IDX) ||
                      ((bidx_r == `OPC_LAST_IDX) && (cnt_r >= `CNT_W'(`HOLD_MCLK))));

  // Data pin synchroniser, first flop read only by the second
  always_ff @(posedge mclk_in) begin
    data_sync_r <= {data_sync_r[0], link.data_line};
  end

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + `CNT_W'(1);
    bidx_nxt  = bidx_r;
    unique case (state_r)
      PS_IDLE: begin
        cnt_nxt = '0;
        if (start_in) state_nxt = PS_STARTUP;   // Lines all low first
      end
      PS_STARTUP: if (phase_end_w) begin
        state_nxt = PS_SETTLE;                  // Reset released after wait
        cnt_nxt   = '0;
      end
      PS_SETTLE: if (phase_end_w) begin
        state_nxt = PS_HI;
        cnt_nxt   = '0;
        bidx_nxt  = 8'h00;
      end
      PS_HI: if (phase_end_w) begin
        state_nxt = PS_LO;
        cnt_nxt   = '0;
      end
      PS_LO: if (phase_end_w) begin
        cnt_nxt = '0;
        if (last_w) begin
          state_nxt = PS_RISE;                  // Closing sequence
        end else begin
          state_nxt = PS_HI;
          bidx_nxt  = bidx_r + 8'h01;
        end
      end
      PS_RISE: if (phase_end_w) begin
        state_nxt = PS_DATALOW;
        cnt_nxt   = '0;
      end
      PS_DATALOW: if (phase_end_w) begin
        state_nxt = PS_FALL;
        cnt_nxt   = '0;
      end
      PS_FALL: if (phase_end_w) begin
        state_nxt = PS_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  // Pin values for the current state, registered below
  wire rstn_w = !(state_r inside {PS_IDLE, PS_STARTUP});
  wire sel_w  = !(state_r inside {PS_IDLE, PS_LO, PS_FALL});
  wire dout_w = (state_r inside {PS_HI, PS_LO, PS_RISE}) ? cur_bit_w : 1'b0;
  wire doe_n_w =
      (state_r == PS_HI)   ? read_data_w :                 // Free during read high
      (state_r == PS_LO)   ? release_lo_w :
      (state_r == PS_RISE) ? is_read_w :                   // Device may still drive
                             1'b0;                         // Data low otherwise

  // Registers
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= PS_IDLE;
      cnt_r   <= '0;
      bidx_r  <= 8'h00;
      op_r    <= OP_PROGRAM;
      wr_r    <= '0;
      rd_r    <= '0;
      rstn_r  <= 1'b0;
      sel_r   <= 1'b0;
      dout_r  <= 1'b0;
      doe_n_r <= 1'b0;
      busy_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      bidx_r  <= bidx_nxt;
      rstn_r  <= rstn_w;
      sel_r   <= sel_w;
      dout_r  <= dout_w;
      doe_n_r <= doe_n_w;
      busy_r  <= (state_nxt != PS_IDLE);
      done_r  <= (state_r == PS_FALL) && phase_end_w;
      if (state_r == PS_IDLE && start_in) begin
        op_r <= nv_op_e'(op_in);
        wr_r <= wr_image_in;
      end
      // Sample read bit late in the high phase, before the fall
      if (state_r == PS_HI && phase_end_w && read_data_w) begin
        rd_r[dpos_w] <= data_s;
      end
    end
  end

  assign link.reset_pin_n    = rstn_r;
  assign link.sel_clk        = sel_r;
  assign link.prog_data_out  = dout_r;
  assign link.prog_data_oe_n = doe_n_r;
  assign rd_image_out        = rd_r;
  assign busy_out            = busy_r;
  assign done_out            = done_r;

endmodule // nvm_serial_programmer

`default_nettype wire

// File: testbench/serial_nvm_program_port_assertions.sv
// Checker for the serial nonvolatile link, both clock domains.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/10ps
`default_nettype none

module serial_nvm_program_port_assertions (
  input  wire logic mclk_in,         // Host clock
  input  wire logic rst_in,          // Host reset
  input  wire logic osc_clk_in,      // Device oscillator
  input  wire logic dev_rst_in,      // Device reset
  input  wire logic reset_pin_n,     // Device reset pin
  input  wire logic sel_clk,         // Select clock
  input  wire logic prog_data_oe_n,  // Host drive enable
  input  wire logic prog_data_out,   // Host drive value
  input  wire logic dev_data_oe_n,   // Device drive enable
  input  wire logic dev_data_out,    // Device drive value
  input  wire logic data_line        // Resolved data pin
);
  logic [7:0] hi_cnt_r;  // Oscillator cycles with select high
  logic [7:0] lo_cnt_r;  // Oscillator cycles with select low
  logic [15:0] st_cnt_r; // Host cycles with select high in reset

  // Startup counter, select high while the reset pin is low
  always_ff @(posedge mclk_in) begin
    if (rst_in || !sel_clk || reset_pin_n) begin
      st_cnt_r <= 16'h0000;
    end else if (st_cnt_r != 16'hffff) begin
      st_cnt_r <= st_cnt_r + 16'h0001;
    end
  end

  // High phase counter, saturating
  always_ff @(posedge osc_clk_in) begin
    if (dev_rst_in || !sel_clk) begin
      hi_cnt_r <= 8'h00;
    end else if (hi_cnt_r != 8'hff) begin
      hi_cnt_r <= hi_cnt_r + 8'h01;
    end
  end

  // Low phase counter, saturating
  always_ff @(posedge osc_clk_in) begin
    if (dev_rst_in || sel_clk) begin
      lo_cnt_r <= 8'h00;
    end else if (lo_cnt_r != 8'hff) begin
      lo_cnt_r <= lo_cnt_r + 8'h01;
    end
  end

  // Data pin quiet after reset release
  sequence s_data_low;
    !data_line [*8];
  endsequence

  // Short startup option: 16 oscillator cycles is 154 host cycles
  property p_startup;
    @(posedge mclk_in) disable iff (rst_in)
      $rose(reset_pin_n) |-> sel_clk && (st_cnt_r >= 16'd154) && !prog_data_out;
  endproperty
  a_startup: assert property (p_startup) else $error("reset pin rose early");

  property p_drv_min;
    @(posedge osc_clk_in) disable iff (dev_rst_in)
      $fell(dev_data_oe_n) |-> sel_clk && $past(sel_clk, 9);
  endproperty
  a_drv_min: assert property (p_drv_min) else $error("device drove too soon");

  property p_release;
    @(posedge osc_clk_in) disable iff (dev_rst_in)
      $rose(sel_clk) |-> ##[0:16] dev_data_oe_n;
  endproperty
  a_release: assert property (p_release) else $error("device kept the pin");

  property p_no_clash;
    @(posedge osc_clk_in) disable iff (dev_rst_in)
      prog_data_oe_n || dev_data_oe_n;
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");

  property p_rd_hold;
    @(posedge osc_clk_in) disable iff (dev_rst_in)
      $fell(sel_clk) && !dev_data_oe_n |=> !dev_data_oe_n && $stable(dev_data_out);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read bit lost at fall");

  property p_hi_phase;
    @(posedge osc_clk_in) disable iff (dev_rst_in)
      $fell(sel_clk) && reset_pin_n |-> hi_cnt_r >= 8'd64;
  endproperty
  a_hi_phase: assert property (p_hi_phase) else $error("select high too short");

  property p_lo_phase;
    @(posedge osc_clk_in) disable iff (dev_rst_in)
      $rose(sel_clk) && reset_pin_n |-> lo_cnt_r >= 8'd64;
  endproperty
  a_lo_phase: assert property (p_lo_phase) else $error("select low too short");

  property p_first_fall;
    @(posedge osc_clk_in) disable iff (dev_rst_in)
      $fell(sel_clk) && reset_pin_n |-> $past(reset_pin_n, 5);
  endproperty
  a_first_fall: assert property (p_first_fall) else $error("fall too near reset");

  property p_rst_data;
    @(posedge osc_clk_in) disable iff (dev_rst_in)
      $rose(reset_pin_n) |-> s_data_low;
  endproperty
  a_rst_data: assert property (p_rst_data) else $error("data high after reset");
endmodule // serial_nvm_program_port_assertions

`default_nettype wire

// File: testbench/serial_nvm_program_port_bench.sv
// Bench joining programmer and device over the link interface.
// Assumes the package, interface and both ends are compiled first.
`timescale 1ns/10ps
`default_nettype none

module serial_nvm_program_port_bench;
  import nvm_port_pkg::*;

  logic       mclk;       // Host clock
  logic       osc_clk;    // Device oscillator
  logic       rst;        // Host reset
  logic       dev_rst;    // Device reset
  logic       start;      // Start pulse
  logic [1:0] op;         // Operation code
  nv_image_t  wr_image;   // Image to program
  nv_image_t  rd_image;   // Image read back
  nv_image_t  nv_array;   // Device array
  nv_image_t  model_img;  // Reference array
  nv_image_t  img;        // Random image
  logic       busy;       // Host busy
  logic       done;       // Host done pulse
  logic       active;     // Device busy
  logic       sel_q;      // Select, one cycle late
  logic       wire_q[$];  // Pin samples at falls
  integer     seed;       // Random seed
  integer     error_cnt;  // Mismatches
  integer     checks;     // Comparisons

  nvm_link_if link_if ();

  nvm_serial_device i_nvm_serial_device (
    .osc_clk_in   (osc_clk),
    .rst_in       (dev_rst),
    .link         (link_if),
    .nv_array_out (nv_array),
    .active_out   (active)
  );

  nvm_serial_programmer #(.STARTUP_CYC(24'd154), .PROG_CYC(24'd700), .ERASE_CYC(24'd700))
    i_nvm_serial_programmer (
    .mclk_in      (mclk),
    .rst_in       (rst),
    .start_in     (start),
    .op_in        (op),
    .wr_image_in  (wr_image),
    .rd_image_out (rd_image),
    .busy_out     (busy),
    .done_out     (done),
    .link         (link_if)
  );

  serial_nvm_program_port_assertions i_checker (
    .mclk_in        (mclk),
    .rst_in         (rst),
    .osc_clk_in     (osc_clk),
    .dev_rst_in     (dev_rst),
    .reset_pin_n    (link_if.reset_pin_n),
    .sel_clk        (link_if.sel_clk),
    .prog_data_oe_n (link_if.prog_data_oe_n),
    .prog_data_out  (link_if.prog_data_out),
    .dev_data_oe_n  (link_if.dev_data_oe_n),
    .dev_data_out   (link_if.dev_data_out),
    .data_line      (link_if.data_line)
  );

  // Host clock, 5 ns
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Oscillator, 48 ns, offset phase
  initial begin
    osc_clk = 1'b0;
    #7;
    forever #24 osc_clk = ~osc_clk;
  end

  // Device reset for three oscillator edges
  initial begin
    dev_rst = 1'b1;
    repeat (3) @(posedge osc_clk);
    dev_rst <= 1'b0;
  end

  // Record the pin at each select fall out of reset
  always @(posedge mclk) begin
    sel_q <= link_if.sel_clk;
    if (sel_q && !link_if.sel_clk && link_if.reset_pin_n) begin
      wire_q.push_back(link_if.data_line);
    end
  end

  task automatic cmp_img(input nv_image_t got, input nv_image_t exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected image at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pin samples: marker, code, payload, closing low
  task automatic chk_wire(input logic [1:0] opc, input nv_image_t exp_img);
    integer k;
    integer n;
    logic   e;
    n = (opc == 2'h3) ? 4 : 132;       // Only erase stops after the code
    cmp_bit(wire_q.size() == n, 1'b1);
    for (k = 0; k < n && k < wire_q.size(); k++) begin
      if (k == 0) e = 1'b1;
      else if (k < 3) e = opc[2-k];
      else if (k == n - 1) e = 1'b0;
      else e = exp_img[k-3];
      cmp_bit(wire_q[k], e);
    end
  endtask

  // One operation; a stray start mid-run must be ignored
  task automatic run_op(input logic [1:0] opc, input nv_image_t wimg);
    integer n;
    wire_q.delete();
    @(posedge mclk);
    start    <= 1'b1;
    op       <= opc;
    wr_image <= wimg;
    @(posedge mclk);
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 300000) begin
      @(posedge mclk);
      n++;
      if (n == 1000) begin
        start <= 1'b1;
        op    <= 2'h3;
      end else if (n == 1001) begin
        start <= 1'b0;
      end
    end
    cmp_bit(done, 1'b1);
    @(posedge mclk);
    cmp_bit(done, 1'b0);
    cmp_bit(busy, 1'b0);
    repeat (40) @(posedge mclk);
    cmp_bit(active, 1'b0);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Cut a hang short; four operations need under 4 ms
  initial begin
    #6000000;
    error_cnt++;
    give_verdict();
  end

  // Main sequence
  initial begin
    seed      = 32'h12c10223;
    error_cnt = 0;
    checks    = 0;
    rst       = 1'b1;
    start     = 1'b0;
    op        = 2'h0;
    wr_image  = '0;
    model_img = '0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (60) @(posedge mclk);
    cmp_img(nv_array, model_img);
    // Program, both end locations set
    img      = {$random(seed), $random(seed), $random(seed), $random(seed)};
    img[0]   = 1'b1;
    img[127] = 1'b1;
    run_op(2'h0, img);
    model_img = model_img | img;
    chk_wire(2'h0, img);
    cmp_img(nv_array, model_img);
    $display("program test ended");
    // Read back
    img = {$random(seed), $random(seed), $random(seed), $random(seed)};
    run_op(2'h1, img);
    chk_wire(2'h1, model_img);
    cmp_img(rd_image, model_img);
    cmp_img(nv_array, model_img);
    $display("read test ended");
    // Unassigned code leaves the array
    run_op(2'h2, img);
    chk_wire(2'h2, img);
    cmp_img(nv_array, model_img);
    $display("unassigned test ended");
    // Bulk erase
    run_op(2'h3, img);
    model_img = '0;
    chk_wire(2'h3, img);
    cmp_img(nv_array, model_img);
    $display("erase test ended");
    give_verdict();
  end
endmodule // serial_nvm_program_port_bench

`default_nettype wire
